// file: src/secp_eeprom.sv
`timescale 1ns/100ps
module secp_eeprom
    import secp_pkg::*;
#(
    parameter int unsigned PROG_CNT = PROG_CYCLES
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Serial pins.
    input  wire logic chip_select_i,
    input  wire logic serial_clock_i,
    input  wire logic serial_in_i,
    output logic      serial_out_o,
    output logic      serial_out_oe_o,
    // Status.
    output logic      write_enabled_o,
    output logic      busy_o
);
    // ****************************************************************
    // Reset and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sk_sync_reg;
    logic [1:0] di_sync_reg;
    logic       sk_prev_reg;
    logic       cs_prev_reg;
    wire        rst_n = rst_sync_reg[1];
    wire        cs    = cs_sync_reg[1];
    wire        di    = di_sync_reg[1];
    wire        sk    = sk_sync_reg[1];
    wire        sk_rise = sk & ~sk_prev_reg & cs;
    wire        cs_fall = cs_prev_reg & ~cs;

    // All checks run on the system clock and stay quiet during reset.
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 2'h0;
            sk_sync_reg <= 2'h0;
            di_sync_reg <= 2'h0;
            sk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], chip_select_i};
            sk_sync_reg <= {sk_sync_reg[0], serial_clock_i};
            di_sync_reg <= {di_sync_reg[0], serial_in_i};
            sk_prev_reg <= sk;
            cs_prev_reg <= cs;
        end
    end

    // ****************************************************************
    // Command sequencer
    // ****************************************************************
    logic [DATA_W-1:0] mem [WORDS];
    secp_state_t       state_reg;
    logic [4:0]        cnt_reg;
    logic [7:0]        cmd_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] shift_reg;
    logic              wen_reg;
    logic              dout_reg;
    logic              status_reg;
    logic              wr_push;
    logic              fifo_ready;

    wire [7:0]  cmd_next  = {cmd_reg[6:0], di};
    wire [1:0]  op        = cmd_next[7:6];
    wire [1:0]  misc      = cmd_next[5:4];
    wire        cmd_end   = (state_reg == SECP_CMD) && sk_rise
                            && (cnt_reg == CMD_BITS - 5'h1);
    wire        word_end  = (cnt_reg == 5'(DATA_W - 1));

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= SECP_IDLE;
            cnt_reg    <= 5'h0;
            cmd_reg    <= 8'h0;
            addr_reg   <= '0;
            shift_reg  <= '0;
            wen_reg    <= 1'b0;
            dout_reg   <= 1'b0;
            status_reg <= 1'b0;
            wr_push    <= 1'b0;
        end else begin
            wr_push <= 1'b0;
            if (!cs) begin
                // A write may only launch on the select fall.
                if (state_reg == SECP_WARM && cs_fall && wen_reg
                    && fifo_ready) begin
                    wr_push    <= 1'b1;
                    status_reg <= 1'b1;
                end
                state_reg <= (state_reg == SECP_WARM || status_reg)
                             ? SECP_DONE : SECP_IDLE;
                cnt_reg   <= 5'h0;
            end else begin
                case (state_reg)
                    SECP_IDLE, SECP_DONE: begin
                        if (sk_rise && di) begin
                            state_reg  <= SECP_CMD;
                            status_reg <= 1'b0;
                            cnt_reg    <= 5'h0;
                        end
                    end
                    SECP_CMD: begin
                        if (sk_rise) begin
                            cmd_reg <= cmd_next;
                            cnt_reg <= cnt_reg + 5'h1;
                        end
                        if (cmd_end) begin
                            cnt_reg  <= 5'h0;
                            addr_reg <= cmd_next[5:0];
                            if (op == OP_READ) begin
                                state_reg <= SECP_READ;
                                dout_reg  <= 1'b0;
                                shift_reg <= mem[cmd_next[5:0]];
                            end else if (op == OP_WRITE) begin
                                state_reg <= SECP_WDATA;
                            end else begin
                                if (misc == MISC_EN) begin
                                    wen_reg <= 1'b1;
                                end else if (misc == MISC_DIS) begin
                                    wen_reg <= 1'b0;
                                end
                                state_reg <= SECP_IDLE;
                            end
                        end
                    end
                    SECP_READ: begin
                        if (sk_rise) begin
                            dout_reg  <= shift_reg[DATA_W-1];
                            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
                            cnt_reg   <= cnt_reg + 5'h1;
                            if (word_end) begin
                                cnt_reg   <= 5'h0;
                                addr_reg  <= addr_reg + 6'h1;
                                shift_reg <= mem[addr_reg + 6'h1];
                            end
                        end
                    end
                    SECP_WDATA: begin
                        if (sk_rise) begin
                            shift_reg <= {shift_reg[DATA_W-2:0], di};
                            cnt_reg   <= cnt_reg + 5'h1;
                            if (word_end) begin
                                state_reg <= SECP_WARM;
                            end
                        end
                    end
                    default: begin
                        state_reg <= SECP_WARM;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Write queue and program engine
    // ****************************************************************
    logic                     pend_valid;
    logic [ADDR_W+DATA_W-1:0] pend_data;
    logic [ADDR_W+DATA_W-1:0] prog_word_reg;
    logic                     prog_busy_reg;
    logic [24:0]              prog_cnt_reg;
    logic                     pop_ready;
    wire                      prog_start = pop_ready & pend_valid;
    wire [ADDR_W-1:0]         prog_addr  =
        prog_word_reg[ADDR_W+DATA_W-1:DATA_W];
    wire                      prog_write = prog_busy_reg
        && prog_cnt_reg == 25'(PROG_CNT - ERASE_CYCLES);

    // The queue keeps a write that lands while the engine is busy.
    secp_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (wr_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({addr_reg, shift_reg}),
        .out_valid_o (pend_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pend_data)
    );
    assign pop_ready = ~prog_busy_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prog_busy_reg <= 1'b0;
            prog_cnt_reg  <= 25'h0;
            prog_word_reg <= '0;
        end else if (prog_start) begin
            prog_busy_reg <= 1'b1;
            prog_cnt_reg  <= 25'(PROG_CNT - 1);
            // The queue moves on at once, so the word is kept here.
            prog_word_reg <= pend_data;
        end else if (prog_busy_reg && prog_cnt_reg == 25'h0) begin
            prog_busy_reg <= 1'b0;
        end else if (prog_busy_reg) begin
            prog_cnt_reg <= prog_cnt_reg - 25'h1;
        end
    end

    // Erase to all ones, then program; the word stays erased meanwhile.
    always_ff @(posedge clk_i) begin
        if (prog_start) begin
            mem[pend_data[ADDR_W+DATA_W-1:DATA_W]] <= MEM_RESET;
        end else if (prog_write) begin
            mem[prog_addr] <= prog_word_reg[DATA_W-1:0];
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    wire busy_any = prog_busy_reg | pend_valid;
    wire show_stat = (state_reg == SECP_DONE) && status_reg;
    assign serial_out_oe_o = cs && (state_reg == SECP_READ
                                    || show_stat);
    assign serial_out_o = (state_reg == SECP_READ) ? dout_reg
                          : ~busy_any;
    assign write_enabled_o = wen_reg;
    assign busy_o          = busy_any;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_wr_fall;
        state_reg == SECP_WARM && cs_fall && wen_reg && fifo_ready;
    endsequence
    sequence s_start;
        cs && sk_rise && di
        && (state_reg == SECP_IDLE || state_reg == SECP_DONE);
    endsequence
    sequence s_word_out;
        state_reg == SECP_READ && cs && sk_rise && word_end;
    endsequence
    // The pin is watched, so a broken select synchroniser shows up here.
    AST_HIZ: assert property (
        !chip_select_i [*3] |-> !serial_out_oe_o)
        else $error("Output driven while idle.");
    AST_START: assert property (
        (state_reg == SECP_IDLE && cs && sk_rise && !di)
        |=> state_reg == SECP_IDLE) else $error("Zero taken as start.");
    AST_GO: assert property (
        s_start |=> state_reg == SECP_CMD)
        else $error("Start bit missed.");
    AST_RESET_SEQ: assert property (
        !cs |=> state_reg inside {SECP_IDLE, SECP_DONE})
        else $error("Sequencer not reset.");
    AST_LAUNCH: assert property (
        s_wr_fall |=> wr_push ##1 busy_o)
        else $error("Write not launched.");
    AST_AFTER_CS: assert property (
        wr_push |-> $past(cs_fall) && $past(state_reg) == SECP_WARM)
        else $error("Write launched before select fell.");
    AST_WARM_HOLD: assert property (
        state_reg == SECP_WARM && cs |=> state_reg == SECP_WARM)
        else $error("Extra clocks disturbed a write.");
    AST_PROTECT: assert property (
        wr_push |-> $past(wen_reg))
        else $error("Write while disabled.");
    AST_LOCKED: assert property (
        !wen_reg && !busy_o |=> !busy_o)
        else $error("Program started while disabled.");
    AST_BUSY: assert property (
        wr_push |=> ##1 busy_o) else $error("Busy missing.");
    AST_STATUS: assert property (
        show_stat && cs |-> serial_out_o == !busy_o)
        else $error("Status level wrong.");
    AST_STAT_OFF: assert property (
        s_start |=> !serial_out_oe_o)
        else $error("Status kept after start bit.");
    AST_DUMMY: assert property (
        cmd_end && op == OP_READ |=> !serial_out_o)
        else $error("Dummy bit not zero.");
    AST_SHIFT: assert property (
        state_reg == SECP_READ && sk_rise && cs
        |=> serial_out_o == $past(shift_reg[DATA_W-1]))
        else $error("Read bit wrong.");
    AST_INC: assert property (
        s_word_out |=> addr_reg == $past(addr_reg) + 6'h1)
        else $error("Read address not advanced.");
    AST_ENABLE: assert property (
        cmd_end && op == OP_MISC && misc == MISC_EN |=> wen_reg)
        else $error("Enable command not taken.");
    AST_MISC_IDLE: assert property (
        cmd_end && op == OP_MISC |=> state_reg == SECP_IDLE)
        else $error("Enable or disable left sequencer busy.");
    AST_ERASE: assert property (
        prog_start |=> mem[prog_addr] == MEM_RESET)
        else $error("Word not erased.");
    AST_PROGRAM: assert property (
        prog_write |=> mem[prog_addr] == prog_word_reg[DATA_W-1:0])
        else $error("Word not programmed.");
    AST_WEN_HOLD: assert property (
        !cmd_end |=> wen_reg == $past(wen_reg))
        else $error("Enable changed.");
endmodule : secp_eeprom

// file: src/secp_fifo.sv
`timescale 1ns/100ps
module secp_fifo #(
    parameter int unsigned WIDTH = 22,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_reg != rd_reg;
    assign out_data_o  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule : secp_fifo

// file: src/secp_pkg.sv
// Operation
// - Sample serial_in on each serial_clock rise while select is high.
// - During reads, update data out on every serial_clock rise, one bit each.
// - After write, select high before next start shows busy low, ready high.
// - Data output is high impedance whenever select is low.
// - Host drops select between commands; select low resets the sequencer.
// - Ignore input until first 1 sampled after select rises: the start bit.
// - Opcode 10 read, 01 write, 00 11xxxx enable, 00 00xxxx disable.
// - Memory holds 64 words of 16 bits, six-bit address.
// - Continued clocking during a read outputs successively higher addresses.
// - Write erases the word then programs new data automatically.
// - Writes are disabled after reset until an enable command.
// - A 0 dummy bit goes out with the last address bit, then 16 bits.
// - Internal write starts when select falls after the 25th clock.
// - Write enable persists until a disable command or reset.
// - When write disabled, writes are ignored but reads work.
package secp_pkg;
    localparam int unsigned ADDR_W      = 6;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned WORDS       = 64;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned CLK_HZ      = 20000000;
    // Program cycle time in microseconds; longest time rounds down.
    localparam int unsigned PROG_TIME_US = 25000;
    localparam int unsigned PROG_CYCLES  =
        (PROG_TIME_US / 1000) * (CLK_HZ / 1000);
    localparam int unsigned ERASE_CYCLES = 4;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_MISC  = 2'h0;
    localparam logic [1:0] MISC_EN  = 2'h3;
    localparam logic [1:0] MISC_DIS = 2'h0;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] WR_LAST  = 5'h18;
    localparam logic [DATA_W-1:0] MEM_RESET = 16'hFFFF;

    typedef enum logic [2:0] {
        SECP_IDLE  = 3'b000,
        SECP_CMD   = 3'b001,
        SECP_READ  = 3'b010,
        SECP_WDATA = 3'b011,
        SECP_WARM  = 3'b100,
        SECP_DONE  = 3'b101
    } secp_state_t;
endpackage : secp_pkg

// file: tb/secp_host_model.sv
`timescale 1ns/100ps
module secp_host_model (
    // System clock, used only to pace the pins.
    input  wire logic clk_i,
    // Serial pins toward the memory.
    output logic      chip_select_o,
    output logic      serial_clock_o,
    output logic      serial_in_o,
    input  wire logic serial_out_i
);
    // ****************************************
    // Pin pacing: one serial clock is 8 clocks.
    // ****************************************
    initial begin
        chip_select_o  = 1'b0;
        serial_clock_o = 1'b0;
        serial_in_o    = 1'b0;
    end

    // Data is set up half a low phase before the rise; the reply is
    // taken two clocks after the fall, mid-way through the low phase, where it has settled.
    task automatic bit_io(input logic b, output logic q);
        serial_in_o = b;
        repeat (2) @(negedge clk_i);
        serial_clock_o = 1'b1;
        repeat (4) @(negedge clk_i);
        serial_clock_o = 1'b0;
        repeat (2) @(negedge clk_i);
        q = serial_out_i;
    endtask : bit_io

    task automatic frame_open(input int zeros);
        logic q;
        chip_select_o = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < zeros; i++) begin
            bit_io(1'b0, q);
        end
    endtask : frame_open

    // The data line is driven to the inverse of its last value.
    task automatic frame_close();
        chip_select_o = 1'b0;
        serial_in_o   = ~serial_in_o;
        repeat (8) @(negedge clk_i);
    endtask : frame_close

    task automatic cmd(input logic [1:0] op, input logic [5:0] a,
                       output logic q);
        bit_io(1'b1, q);
        for (int i = 1; i >= 0; i--) begin
            bit_io(op[i], q);
        end
        for (int i = 5; i >= 0; i--) begin
            bit_io(a[i], q);
        end
    endtask : cmd

    task automatic word_io(input logic [15:0] d, output logic [15:0] q);
        for (int i = 15; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
    endtask : word_io

    // Status polling keeps the data line low so no start bit is seen.
    task automatic select_high();
        serial_in_o   = 1'b0;
        chip_select_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : select_high
endmodule : secp_host_model

// file: tb/serial_eeprom_command_port_tb_top.sv
`timescale 1ns/100ps
module serial_eeprom_command_port_tb_top
    import secp_pkg::*;
;
    localparam int unsigned PCNT = 40;
    logic        clk_i;
    logic        nrst_i;
    logic        cs;
    logic        sk;
    logic        di;
    logic        dout;
    logic        doe;
    logic        wen;
    logic        busy;
    logic        q;
    logic [15:0] w;
    int          n_fail;
    int          n_tests;
    wire         do_w = doe ? dout : 1'bz;

    secp_eeprom #(.PROG_CNT(PCNT)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .chip_select_i(cs),
        .serial_clock_i(sk), .serial_in_i(di), .serial_out_o(dout),
        .serial_out_oe_o(doe), .write_enabled_o(wen), .busy_o(busy));
    secp_host_model host (
        .clk_i(clk_i), .chip_select_o(cs), .serial_clock_o(sk),
        .serial_in_o(di), .serial_out_i(do_w));

    // ****************************************
    // Compare and closing tasks.
    // ****************************************
    task automatic chk1(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", s, e, g);
        end
    endtask : chk1

    task automatic chk16(input string s, input logic [15:0] e,
                         input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask : chk16

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic do_write(input logic [5:0] a, input logic [15:0] d);
        host.frame_open(0);
        host.cmd(OP_WRITE, a, q);
        host.word_io(d, w);
        host.frame_close();
    endtask : do_write

    task automatic t_misc(input logic [1:0] sel, input logic e);
        host.frame_open(1);
        host.cmd(OP_MISC, {sel, 4'hA}, q);
        host.frame_close();
        chk1("write enable", e, wen);
    endtask : t_misc

    task automatic t_ignored(input logic [5:0] a, input logic [15:0] d);
        do_write(a, d);
        chk1("busy ignored", 1'b0, busy);
    endtask : t_ignored

    task automatic t_write(input logic [5:0] a, input logic [15:0] d);
        do_write(a, d);
        chk1("busy", 1'b1, busy);
        chk1("oe low", 1'b0, doe);
        host.select_high();
        chk1("status oe", 1'b1, doe);
        chk1("status busy", 1'b0, dout);
        for (int i = 0; i < PCNT * 4 && busy !== 1'b0; i++) begin
            @(negedge clk_i);
        end
        chk1("busy end", 1'b0, busy);
        repeat (4) @(negedge clk_i);
        chk1("status ready", 1'b1, dout);
        host.frame_close();
        chk1("enable kept", 1'b1, wen);
    endtask : t_write

    task automatic t_abort(input logic [5:0] a);
        host.frame_open(0);
        host.cmd(OP_WRITE, a, q);
        host.frame_close();
        chk1("busy abort", 1'b0, busy);
    endtask : t_abort

    task automatic t_read(input logic [5:0] a, input logic [15:0] e0,
                          input logic [15:0] e1);
        host.frame_open(2);
        host.cmd(OP_READ, a, q);
        chk1("dummy bit", 1'b0, q);
        chk1("read oe", 1'b1, doe);
        host.word_io(16'h0000, w);
        chk16("read word", e0, w);
        host.word_io(16'h0000, w);
        chk16("next word", e1, w);
        host.frame_close();
        chk1("oe idle", 1'b0, doe);
    endtask : t_read

    // ****************************************
    // Clock, reset, sequence and watchdog.
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        #2000000;
        n_fail++;
        test_done();
    end

    initial begin
        n_fail  = 0;
        n_tests = 0;
        nrst_i  = 1'b0;
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        chk1("oe reset", 1'b0, doe);
        chk1("enable reset", 1'b0, wen);
        t_ignored(6'h05, 16'h0F0F);
        t_misc(MISC_EN, 1'b1);
        t_write(6'h3F, 16'h00FF);
        t_write(6'h3F, 16'hA5C3);
        t_write(6'h00, 16'h1234);
        t_write(6'h01, 16'h5A0F);
        t_abort(6'h00);
        t_read(6'h3F, 16'hA5C3, 16'h1234);
        t_misc(MISC_DIS, 1'b0);
        t_ignored(6'h00, 16'hFFFF);
        t_read(6'h00, 16'h1234, 16'h5A0F);
        test_done();
    end
endmodule : serial_eeprom_command_port_tb_top
